/* torque_pkg.sv */
// Shared widths, codes, defaults and timing for the torque and load detection block
package torque_pkg;

    localparam int SEL_W   = 4;
    localparam int LEVEL_W = 9;
    localparam int TIME_W  = 7;
    localparam int SPEED_W = 12;
    localparam int HOURS_W = 16;
    localparam int FUNC_W  = 8;

    // Selection codes of both detectors and the weakening function; only off and max are shared
    localparam logic [SEL_W-1:0] SEL_OFF        = 4'h0;
    localparam logic [SEL_W-1:0] SEL_MAX        = 4'h8;
    localparam logic [SEL_W-1:0] SEL_UNDER_MIN  = 4'h5;
    localparam logic [SEL_W-1:0] WEAK_ABOVE_MAX = 4'h4;

    // Levels in whole percent of the reference quantity
    localparam logic [LEVEL_W-1:0] LEVEL_MAX   = 9'h12c;
    localparam logic [LEVEL_W-1:0] LEVEL_DFLT  = 9'h096;
    localparam logic [LEVEL_W-1:0] HYST_PCT    = 9'h00a;

    // Times in tenths of a second
    localparam logic [TIME_W-1:0] TIME_MAX     = 7'h64;
    localparam logic [TIME_W-1:0] TIME_DFLT    = 7'h01;

    // Speed level in tenths of a percent of maximum frequency, signed
    localparam logic signed [SPEED_W-1:0] SPEED_LEVEL_MAX  = 12'sh44c;
    localparam logic signed [SPEED_W-1:0] SPEED_LEVEL_DFLT = 12'sh44c;
    localparam logic [HOURS_W-1:0]        START_HOURS_DFLT = 16'h0000;

    // Function codes of the analog input and the digital output
    localparam logic [FUNC_W-1:0] AIN_FUNC_LEVEL1 = 8'h07;
    localparam logic [FUNC_W-1:0] DOUT_FUNC_WEAK  = 8'h22;

    // Control modes
    localparam logic [1:0] MODE_VF  = 2'h0;
    localparam logic [1:0] MODE_OLV = 2'h1;
    localparam logic [1:0] MODE_CLV = 2'h2;

    // One time unit is 0.1 s
    localparam int CLK_PERIOD_NS = 50;
    localparam int TIME_UNIT_NS  = 100000000;
    localparam int TICK_CYCLES   = TIME_UNIT_NS / CLK_PERIOD_NS;
    localparam int TICK_W        = 21;

endpackage

/* detect_if.sv */
// Link between a detector and its persistence timer
`timescale 1ns/1ns
interface detect_if;
    logic                           cond;
    logic                           qualify;
    logic                           tick;
    logic [torque_pkg::TIME_W-1:0]  limit;
    logic                           hit;

    modport timer (input cond, input qualify, input tick, input limit, output hit);
    modport user  (output cond, output qualify, output tick, output limit, input hit);
endinterface

/* persist_timer.sv */
// Persistence timer counting time units while a qualified condition holds
`timescale 1ns/1ns
module persist_timer (
    input  wire logic   clk_sys,
    input  wire logic   sys_rst,
    detect_if.timer     link
);
    logic [torque_pkg::TIME_W-1:0] count_r;
    logic [torque_pkg::TIME_W-1:0] count_nxt;
    wire                           armed  = link.cond && link.qualify;
    wire                           full   = count_r >= link.limit;

    // Any lapse drops the count back to zero
    assign count_nxt = !armed ? '0 :                                           // RULE23
                       (link.tick && !full) ? count_r + 1'b1 : count_r;
    assign link.hit  = armed && full;                                          // RULE12

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            count_r <= '0;
        else
            count_r <= count_nxt;
    end
endmodule

/* level_check.sv */
// Level comparison with hysteresis for over- or undertorque
`timescale 1ns/1ns
module level_check (
    input  wire logic [torque_pkg::LEVEL_W-1:0] meas,
    input  wire logic [torque_pkg::LEVEL_W-1:0] level,
    input  wire logic                           under,
    input  wire logic                           held,
    output wire logic                           cond
);
    wire [torque_pkg::LEVEL_W:0] measX  = {1'b0, meas};
    wire [torque_pkg::LEVEL_W:0] levelX = {1'b0, level};
    wire [torque_pkg::LEVEL_W:0] hystX  = {1'b0, torque_pkg::HYST_PCT};

    // Once detected the condition stays until it backs off by the hysteresis
    wire overCond  = held ? (measX + hystX > levelX) : (measX > levelX);      // RULE22
    wire underCond = held ? (measX < levelX + hystX) : (measX < levelX);      // RULE22

    assign cond = under ? underCond : overCond;
endmodule

/* torque_load_detection.sv */
// Torque detectors 1 and 2 with mechanical weakening detection
// Functional notes
// RULE1 - Detect only after level exceeded past time
// RULE2 - Selection 0 to 8, zero disables
// RULE3 - Selections 1,3 overtorque only at speed agree
// RULE4 - Selections 2,4 overtorque whenever run active
// RULE5 - Alarm selections keep running, raise alarm
// RULE6 - Fault selections stop and latch fault
// RULE7 - Selections 5,7 undertorque at speed agree
// RULE8 - Selections 6,8 undertorque whenever run active
// RULE9 - Per-detector level 0 to 300 percent
// RULE10 - Analog function 7 replaces level 1 only
// RULE11 - Level reference: drive current, CLV motor current
// RULE12 - Detection time 0.0 to 10.0 s
// RULE13 - Weakening active once run hours reach start
// RULE14 - Weakening reuses detector 1 settings, own event
// RULE15 - Weakening selection: 1-4 above, 5-8 below
// RULE16 - Weakening 1,2,5,6 continue with alarm
// RULE17 - Weakening 3,4,7,8 stop with fault
// RULE18 - Unsigned weakening selections use absolute level
// RULE19 - Weakening speed level signed, +-110 percent
// RULE20 - Weakening condition persists for weakening time
// RULE21 - Digital output code 22 shows weakening
// RULE22 - Ten percent hysteresis before condition clears
// RULE23 - Timer restarts whenever condition lapses
// RULE24 - Alarms self-clear, faults held until reset
`timescale 1ns/1ns
module torque_load_detection #(
    parameter int TICK_CYCLES = torque_pkg::TICK_CYCLES
) (
    input  wire logic                                  clk_sys,
    input  wire logic                                  sys_rst,
    input  wire logic                                  runCmd,
    input  wire logic                                  speedAgree,
    input  wire logic [1:0]                            controlMode,
    input  wire logic [torque_pkg::LEVEL_W-1:0]        currentPctDrive,
    input  wire logic [torque_pkg::LEVEL_W-1:0]        currentPctMotor,
    input  wire logic signed [torque_pkg::SPEED_W-1:0] outputSpeed,
    input  wire logic [torque_pkg::SEL_W-1:0]          detect1_select,
    input  wire logic [torque_pkg::SEL_W-1:0]          detect2_select,
    input  wire logic [torque_pkg::LEVEL_W-1:0]        detect1_level,
    input  wire logic [torque_pkg::LEVEL_W-1:0]        detect2_level,
    input  wire logic [torque_pkg::TIME_W-1:0]         detect1_time,
    input  wire logic [torque_pkg::TIME_W-1:0]         detect2_time,
    input  wire logic [torque_pkg::FUNC_W-1:0]         analog_input_function,
    input  wire logic [torque_pkg::LEVEL_W-1:0]        analogLevel,
    input  wire logic [torque_pkg::SEL_W-1:0]          weakening_select,
    input  wire logic signed [torque_pkg::SPEED_W-1:0] weakening_speed_level,
    input  wire logic [torque_pkg::TIME_W-1:0]         weakening_time,
    input  wire logic [torque_pkg::HOURS_W-1:0]        weakening_start_hours,
    input  wire logic [torque_pkg::HOURS_W-1:0]        cumulative_run_hours,
    input  wire logic [torque_pkg::FUNC_W-1:0]         digital_output_function,
    input  wire logic                                  faultReset,
    output logic                                       overtorque1_event,
    output logic                                       undertorque1_event,
    output logic                                       overtorque2_event,
    output logic                                       undertorque2_event,
    output logic                                       torque1Fault,
    output logic                                       torque2Fault,
    output logic                                       weakening_event,
    output logic                                       weakening_under_event,
    output logic                                       weakeningFault,
    output logic                                       weakeningActive,
    output logic                                       stopRequest,
    output logic                                       digitalOut
);
    typedef enum logic [1:0] {WEAK_IDLE, WEAK_ARMED, WEAK_TRIPPED} weak_state_t;

    // Time-unit prescaler; settings are not registered, so a setting change takes effect at once
    logic [torque_pkg::TICK_W-1:0] tickCnt_r;
    logic [torque_pkg::TICK_W-1:0] tickCnt_nxt;
    wire                           tickWrap = tickCnt_r >= torque_pkg::TICK_W'(TICK_CYCLES - 1);
    wire                           tick     = tickWrap;

    assign tickCnt_nxt = tickWrap ? '0 : tickCnt_r + 1'b1;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            tickCnt_r <= '0;
        else
            tickCnt_r <= tickCnt_nxt;
    end

    // Measured quantity follows the control mode
    wire [torque_pkg::LEVEL_W-1:0] meas =
        (controlMode == torque_pkg::MODE_CLV) ? currentPctMotor : currentPctDrive; // RULE11

    // Analog input can only override detector 1
    wire useAnalog = analog_input_function == torque_pkg::AIN_FUNC_LEVEL1;
    wire [torque_pkg::LEVEL_W-1:0] level1Raw = useAnalog ? analogLevel : detect1_level; // RULE10

    // Levels above the documented span are held at the top of the span
    wire [torque_pkg::LEVEL_W-1:0] level1 =
        (level1Raw > torque_pkg::LEVEL_MAX) ? torque_pkg::LEVEL_MAX : level1Raw;  // RULE9
    wire [torque_pkg::LEVEL_W-1:0] level2 =
        (detect2_level > torque_pkg::LEVEL_MAX) ? torque_pkg::LEVEL_MAX : detect2_level; // RULE9

    wire [torque_pkg::TIME_W-1:0] time1 =
        (detect1_time > torque_pkg::TIME_MAX) ? torque_pkg::TIME_MAX : detect1_time; // RULE12
    wire [torque_pkg::TIME_W-1:0] time2 =
        (detect2_time > torque_pkg::TIME_MAX) ? torque_pkg::TIME_MAX : detect2_time; // RULE12
    wire [torque_pkg::TIME_W-1:0] timeW =
        (weakening_time > torque_pkg::TIME_MAX) ? torque_pkg::TIME_MAX : weakening_time; // RULE20

    // Per-detector decode
    logic [torque_pkg::SEL_W-1:0]   sel      [2];
    logic [torque_pkg::LEVEL_W-1:0] lvl      [2];
    logic [torque_pkg::TIME_W-1:0]  tim      [2];
    logic [1:0]                     selOn;
    logic [1:0]                     selUnder;
    logic [1:0]                     selFault;
    logic [1:0]                     qualify;
    logic [1:0]                     cond;
    logic [1:0]                     hit;
    logic [1:0]                     held_r;
    logic [1:0]                     faultLatch_r;
    logic [1:0]                     faultLatch_nxt;
    logic [1:0]                     overAlarm_r;
    logic [1:0]                     underAlarm_r;

    assign sel[0] = detect1_select;
    assign sel[1] = detect2_select;
    assign lvl[0] = level1;
    assign lvl[1] = level2;
    assign tim[0] = time1;
    assign tim[1] = time2;

    detect_if det0Link ();
    detect_if det1Link ();

    for (genvar d = 0; d < 2; d++)
    begin : g_det
        // Values above 8 are treated like 0
        assign selOn[d]    = sel[d] != torque_pkg::SEL_OFF && sel[d] <= torque_pkg::SEL_MAX; // RULE2
        assign selUnder[d] = sel[d] >= torque_pkg::SEL_UNDER_MIN;             // RULE7 RULE8
        // Codes 3,4,7,8 stop the drive, the rest only warn
        assign selFault[d] = sel[d] inside {4'h3, 4'h4, 4'h7, 4'h8};          // RULE5 RULE6
        // Odd codes wait for speed agree, even codes only need a run command
        assign qualify[d]  = selOn[d] && runCmd && (!sel[d][0] ? 1'b1 :        // RULE4 RULE8
                             speedAgree);                                       // RULE3 RULE7

        level_check u_level (
            .meas  (meas),
            .level (lvl[d]),
            .under (selUnder[d]),
            .held  (held_r[d]),
            .cond  (cond[d])
        );
    end

    // Fault types latch and stop; alarm types follow the condition
    wire [1:0] isFault;
    assign isFault = selFault;                                                 // RULE6

    assign det0Link.cond    = cond[0];
    assign det0Link.qualify = qualify[0];
    assign det0Link.tick    = tick;
    assign det0Link.limit   = tim[0];
    assign hit[0]           = det0Link.hit;
    assign det1Link.cond    = cond[1];
    assign det1Link.qualify = qualify[1];
    assign det1Link.tick    = tick;
    assign det1Link.limit   = tim[1];
    assign hit[1]           = det1Link.hit;

    persist_timer u_timer0 (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .link    (det0Link)
    );

    persist_timer u_timer1 (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .link    (det1Link)
    );

    // A new detection wins over a reset arriving in the same cycle
    assign faultLatch_nxt = (faultLatch_r & {2{!faultReset}}) | (hit & isFault); // RULE6 RULE24

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            held_r       <= '0;
            faultLatch_r <= '0;
            overAlarm_r  <= '0;
            underAlarm_r <= '0;
        end
        else
        begin
            held_r       <= hit;                                                // RULE22
            faultLatch_r <= faultLatch_nxt;
            overAlarm_r  <= hit & ~isFault & ~selUnder;                         // RULE1 RULE5 RULE24
            underAlarm_r <= hit & ~isFault & selUnder;                          // RULE1 RULE5 RULE24
        end
    end

    // Mechanical weakening
    logic [torque_pkg::SEL_W-1:0] wsel;
    assign wsel = weakening_select;

    wire wOn       = wsel != torque_pkg::SEL_OFF && wsel <= torque_pkg::SEL_MAX;  // RULE15
    wire wAbove    = wsel <= torque_pkg::WEAK_ABOVE_MAX;                          // RULE15
    wire wUnsigned = !wsel[0];                                                    // RULE18
    wire wFault    = wsel == 4'h3 || wsel == 4'h4 || wsel == 4'h7 || wsel == 4'h8; // RULE16 RULE17

    // Magnitudes are one bit wider so that the most negative value cannot wrap
    wire signed [torque_pkg::SPEED_W:0] spdX =
        {outputSpeed[torque_pkg::SPEED_W-1], outputSpeed};
    wire signed [torque_pkg::SPEED_W:0] lvlClip =
        (weakening_speed_level > torque_pkg::SPEED_LEVEL_MAX) ? torque_pkg::SPEED_LEVEL_MAX :
        (weakening_speed_level < -torque_pkg::SPEED_LEVEL_MAX) ? -torque_pkg::SPEED_LEVEL_MAX :
        weakening_speed_level;                                                   // RULE19
    wire signed [torque_pkg::SPEED_W:0] spdAbs = (spdX < 0) ? -spdX : spdX;
    wire signed [torque_pkg::SPEED_W:0] lvlAbs = (lvlClip < 0) ? -lvlClip : lvlClip;
    wire signed [torque_pkg::SPEED_W:0] spdCmp = wUnsigned ? spdAbs : spdX;     // RULE18
    wire signed [torque_pkg::SPEED_W:0] lvlCmp = wUnsigned ? lvlAbs : lvlClip;  // RULE18
    wire inRange = wAbove ? (spdCmp > lvlCmp) : (spdCmp < lvlCmp);              // RULE15

    wire hoursReached = cumulative_run_hours >= weakening_start_hours;          // RULE13

    weak_state_t wState_r;
    weak_state_t wState_nxt;
    logic        wFault_r;
    logic        wFault_nxt;
    logic        wOverAlarm_r;
    logic        wUnderAlarm_r;
    logic        wDetect;
    logic        digitalOut_r;

    detect_if weakLink ();

    // Torque condition, selection and run/agree qualification borrowed from detector 1
    assign weakLink.cond    = cond[0];                                          // RULE14
    assign weakLink.qualify = qualify[0] && wOn && inRange &&
                              wState_r != WEAK_IDLE;                            // RULE13 RULE14
    assign weakLink.tick    = tick;
    assign weakLink.limit   = timeW;                                            // RULE20
    assign wDetect          = weakLink.hit;

    persist_timer u_timerW (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .link    (weakLink)
    );

    always_comb
    begin
        wState_nxt = wState_r;
        case (wState_r)
            WEAK_IDLE:
                if (hoursReached)
                    wState_nxt = WEAK_ARMED;                                     // RULE13
            WEAK_ARMED:
                if (!hoursReached)
                    wState_nxt = WEAK_IDLE;
                else if (wDetect && wFault)
                    wState_nxt = WEAK_TRIPPED;                                   // RULE17
            WEAK_TRIPPED:
                if (faultReset && !(wDetect && wFault))
                    wState_nxt = hoursReached ? WEAK_ARMED : WEAK_IDLE;         // RULE24
            default:
                wState_nxt = WEAK_IDLE;
        endcase
    end

    assign wFault_nxt = wState_nxt == WEAK_TRIPPED;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            wState_r      <= WEAK_IDLE;
            wFault_r      <= 1'b0;
            wOverAlarm_r  <= 1'b0;
            wUnderAlarm_r <= 1'b0;
            digitalOut_r  <= 1'b0;
        end
        else
        begin
            wState_r      <= wState_nxt;
            wFault_r      <= wFault_nxt;
            wOverAlarm_r  <= wDetect && !wFault && !selUnder[0];                // RULE16 RULE24
            wUnderAlarm_r <= wDetect && !wFault && selUnder[0];                 // RULE16 RULE24
            digitalOut_r  <= (digital_output_function == torque_pkg::DOUT_FUNC_WEAK) &&
                             (wDetect || wFault_nxt);                           // RULE21
        end
    end

    // Outputs
    assign overtorque1_event     = overAlarm_r[0];
    assign undertorque1_event    = underAlarm_r[0];
    assign overtorque2_event     = overAlarm_r[1];
    assign undertorque2_event    = underAlarm_r[1];
    assign torque1Fault          = faultLatch_r[0];
    assign torque2Fault          = faultLatch_r[1];
    assign weakening_event       = wOverAlarm_r;
    assign weakening_under_event = wUnderAlarm_r;
    assign weakeningFault        = wFault_r;
    assign weakeningActive       = wState_r != WEAK_IDLE;
    // Stop is held while any fault stays latched
    assign stopRequest           = |faultLatch_r || wFault_r;                    // RULE6 RULE17
    assign digitalOut            = digitalOut_r;

endmodule

/* run_sequencer.sv */
// Run sequencer model driving run and speed agree
`timescale 1ns/1ns
module run_sequencer #(
    parameter int ACCEL_CYCLES = 12
) (
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic startRun,
    input  wire logic stopRequest,
    output logic      runCmd,
    output logic      speedAgree
);
    logic [7:0] accel_r;
    // Stop drops run at once; a fault must be cleared first
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || !startRun || stopRequest)
        begin
            runCmd  <= 1'b0;
            accel_r <= 8'h00;
        end
        else
        begin
            runCmd <= 1'b1;
            if (accel_r != 8'(ACCEL_CYCLES))
                accel_r <= accel_r + 8'h01;
        end
    end
    // Agree only after the ramp
    assign speedAgree = runCmd && (accel_r == 8'(ACCEL_CYCLES));
endmodule

/* torque_chk.sv */
// Port assertions of the torque detection block
`timescale 1ns/1ns
module torque_chk #(
    parameter int TICK_CYCLES = 4
) (
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic        runCmd,
    input wire logic [3:0]  detect1_select,
    input wire logic [6:0]  detect1_time,
    input wire logic [15:0] weakening_start_hours,
    input wire logic [15:0] cumulative_run_hours,
    input wire logic [7:0]  digital_output_function,
    input wire logic        faultReset,
    input logic             overtorque1_event,
    input logic             undertorque1_event,
    input logic             overtorque2_event,
    input logic             undertorque2_event,
    input logic             torque1Fault,
    input logic             torque2Fault,
    input logic             weakening_event,
    input logic             weakening_under_event,
    input logic             weakeningFault,
    input logic             weakeningActive,
    input logic             stopRequest,
    input logic             digitalOut
);
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    logic [7:0] runLen_r;
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || !runCmd)
            runLen_r <= 8'h00;
        else if (runLen_r != 8'hff)
            runLen_r <= runLen_r + 8'h01;
    end
    sequence stopped3;
        !runCmd [*3];
    endsequence
    stop_or_faults_a:
        assert property (stopRequest == (torque1Fault || torque2Fault || weakeningFault))
        else $error("stop not equal faults");
    idle_no_alarm_a:
        assert property (stopped3 |-> !overtorque1_event && !undertorque1_event
            && !overtorque2_event && !undertorque2_event)
        else $error("alarm while stopped");
    fault_hold_a:
        assert property (torque1Fault && !faultReset |=> torque1Fault)
        else $error("fault dropped");
    fault_no_alarm_a:
        assert property ($past(detect1_select) inside {4'h3, 4'h4, 4'h7, 4'h8}
            |-> !overtorque1_event && !undertorque1_event)
        else $error("alarm on fault select");
    off_no_event_a:
        assert property ($past(detect1_select) == 4'h0 |-> !overtorque1_event && !undertorque1_event)
        else $error("event while disabled");
    dout_off_a:
        assert property ($past(digital_output_function) != 8'h22 |-> !digitalOut)
        else $error("output without function");
    dout_fault_a:
        assert property (weakeningFault && $past(digital_output_function) == 8'h22 |-> digitalOut)
        else $error("output missed fault");
    weak_start_a:
        assert property (!$past(sys_rst) && $past(cumulative_run_hours >= weakening_start_hours)
            |-> weakeningActive)
        else $error("weakening not active");
    weak_gate_a:
        assert property (!weakeningActive && $past(!weakeningActive)
            |=> !weakening_event && !weakening_under_event)
        else $error("weakening before start");
    persist_time_a:
        assert property ($rose(overtorque1_event) && detect1_time == 7'h02
            |-> runLen_r >= 8'(TICK_CYCLES + 1))
        else $error("alarm too early");
endmodule

/* tb.sv */
// Testbench of the torque detection block
`timescale 1ns/1ns
module tb;
    logic        clk_sys, sys_rst, startRun, runCmd, speedAgree, faultReset;
    logic [1:0]  controlMode;
    logic [8:0]  curDrive, curMotor, level1, level2, anaLevel;
    logic signed [11:0] outSpeed, weakLevel;
    logic [3:0]  sel1, sel2, weakSel;
    logic [6:0]  time1, time2, weakTime;
    logic [7:0]  anaFunc, doutFunc;
    logic [15:0] startHours, runHours;
    wire  [8:0]  outs;
    wire         stopRequest, digitalOut, weakeningActive;
    int          miscompares, checkCount, cycles;
    torque_load_detection #(.TICK_CYCLES(4)) DUT (.clk_sys, .sys_rst, .runCmd, .speedAgree,
        .controlMode, .currentPctDrive(curDrive), .currentPctMotor(curMotor),
        .outputSpeed(outSpeed),
        .detect1_select(sel1), .detect2_select(sel2), .detect1_level(level1),
        .detect2_level(level2), .detect1_time(time1), .detect2_time(time2),
        .analog_input_function(anaFunc), .analogLevel(anaLevel), .weakening_select(weakSel),
        .weakening_speed_level(weakLevel), .weakening_time(weakTime),
        .weakening_start_hours(startHours), .cumulative_run_hours(runHours),
        .digital_output_function(doutFunc), .faultReset,
        .overtorque1_event(outs[0]), .undertorque1_event(outs[1]), .overtorque2_event(outs[2]),
        .undertorque2_event(outs[3]), .torque1Fault(outs[4]), .torque2Fault(outs[5]),
        .weakening_event(outs[6]), .weakening_under_event(outs[7]), .weakeningFault(outs[8]),
        .weakeningActive, .stopRequest, .digitalOut);
    run_sequencer #(.ACCEL_CYCLES(12)) partner (.clk_sys, .sys_rst, .startRun, .stopRequest,
        .runCmd, .speedAgree);
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    task final_report;
        $display("Comparisons %0d, mismatches %0d", checkCount, miscompares);
        if (miscompares == 0 && checkCount > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Sequence needs under 1000 cycles
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            miscompares++;
            final_report;
        end
    end
    task chk(input logic [8:0] got, input logic [8:0] exp);
        checkCount++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task wait_out(input logic [8:0] mask);
        for (int n = 0; n < 40 && (outs & mask) == 9'h000; n++)
            step(1);
    endtask
    task run(input logic [3:0] s1, input logic [3:0] s2, input logic [8:0] cur);
        @(posedge clk_sys);
        sel1 <= s1;
        sel2 <= s2;
        curDrive <= cur;
        startRun <= 1'b1;
    endtask
    // Clear faults between scenarios
    task idle;
        @(posedge clk_sys);
        startRun <= 1'b0;
        sel1 <= 4'h0;
        sel2 <= 4'h0;
        weakSel <= 4'h0;
        faultReset <= 1'b1;
        step(2);
        faultReset <= 1'b0;
        step(2);
    endtask
    task sel_sweep;
        logic under, fault;
        for (int i = 1; i <= 8; i++)
        begin
            under = (i >= 5);
            fault = (i == 3 || i == 4 || i == 7 || i == 8);
            run(4'(i), 4'h0, under ? 9'h032 : 9'h078);
            step(4);
            chk(outs, 9'h000);
            step(6);
            chk(outs == 9'h000, 9'(i % 2));
            wait_out(9'h013);
            chk({outs[0], outs[1], outs[4], stopRequest}, {~under & ~fault, under & ~fault, fault, fault});
            idle;
        end
    endtask
    task hysteresis;
        run(4'h2, 4'h0, 9'h078);
        wait_out(9'h001);
        @(posedge clk_sys);
        curDrive <= 9'h05f;
        step(4);
        chk(outs[0], 1'b1);
        curDrive <= 9'h055;
        step(3);
        chk(outs[0], 1'b0);
        idle;
    endtask
    task fault_clv;
        controlMode <= 2'h2;
        curMotor <= 9'h050;
        level2 <= 9'h032;
        run(4'h0, 4'h4, 9'h00a);
        wait_out(9'h020);
        step(5);
        chk({outs[5], stopRequest, outs[0]}, 3'b110);
        startRun <= 1'b0;
        faultReset <= 1'b1;
        step(1);
        faultReset <= 1'b0;
        chk({outs[5], stopRequest}, 2'b00);
        controlMode <= 2'h0;
        idle;
    endtask
    task analog_level;
        anaFunc <= 8'h07;
        level1 <= 9'h0c8;
        level2 <= 9'h0c8;
        run(4'h2, 4'h6, 9'h064);
        step(16);
        chk({outs[3], outs[2], outs[0]}, 3'b101);
        anaFunc <= 8'h00;
        level1 <= 9'h064;
        idle;
    endtask
    task weakening;
        run(4'h2, 4'h0, 9'h078);
        weakSel <= 4'h1;
        step(16);
        chk({weakeningActive, outs[6], outs[0]}, 3'b001);
        idle;
        startHours <= 16'h0000;
        run(4'h2, 4'h0, 9'h078);
        weakSel <= 4'h4;
        wait_out(9'h100);
        step(1);
        chk({outs[8], outs[6], digitalOut}, 3'b101);
        idle;
        run(4'h2, 4'h0, 9'h078);
        weakSel <= 4'h2;
        outSpeed <= 12'sh12c;
        step(16);
        chk({outs[6], outs[0]}, 2'b01);
        weakSel <= 4'h1;
        wait_out(9'h040);
        chk({outs[6], outs[8]}, 2'b10);
        idle;
    endtask
    initial
    begin
        {startRun, faultReset, controlMode, sel1, sel2, weakSel, anaFunc, anaLevel} = '0;
        {curMotor, miscompares, checkCount, cycles} = '0;
        {curDrive, level1, level2, time1, time2} = {9'h064, 9'h064, 9'h064, 7'h02, 7'h02};
        {outSpeed, weakLevel, weakTime} = {12'sh258, 12'she0c, 7'h01};
        {startHours, runHours, doutFunc} = {16'h0064, 16'h0032, 8'h22};
        sys_rst = 1'b1;
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        weakening;
        sel_sweep;
        hysteresis;
        fault_clv;
        analog_level;
        final_report;
    end
endmodule
bind torque_load_detection torque_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clk_sys, .sys_rst,
    .runCmd, .detect1_select, .detect1_time, .weakening_start_hours, .cumulative_run_hours,
    .faultReset, .digital_output_function, .overtorque1_event, .undertorque1_event,
    .overtorque2_event, .undertorque2_event, .torque1Fault, .torque2Fault, .weakening_event,
    .weakening_under_event, .weakeningFault, .weakeningActive, .stopRequest, .digitalOut);
